//--- src/vmf_pkg.sv
// Package of constants and carriers for the vehicle message framer
package vmf_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int BAUD = 57_600;
    localparam int BIT_CYCLES = CLK_HZ / BAUD;
    localparam int TRIG_NS = 1000;
    localparam int TRIG_CYCLES = (TRIG_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 9;
    localparam logic [7:0] SYNC_FIRST = 8'ha5;
    localparam logic [7:0] SYNC_SECOND = 8'h5a;
    localparam logic [7:0] MSG_B1_DET = 8'h01;
    localparam logic [7:0] MSG_B2_DET = 8'h02;
    localparam logic [7:0] MSG_B1_END = 8'h03;
    localparam logic [7:0] MSG_B2_END = 8'h04;
    localparam logic [7:0] MSG_CLASSIFY = 8'h05;
    localparam logic [7:0] MSG_SELF_TEST = 8'h07;
    localparam logic [7:0] VEH_NUM_RESET = 8'hff;
    localparam logic [3:0] MAX_BODY = 4'h8;

    typedef struct packed {
        logic [7:0] left;
        logic [7:0] right;
    } vmf_edges_s;

    typedef struct packed {
        logic [7:0] vclass;
        logic [15:0] length;
        logic [7:0] width;
        logic [7:0] speed;
    } vmf_class_s;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } vmf_byte_s;
endpackage : vmf_pkg

//--- src/vmf_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
module vmf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rptr];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wptr <= wptr + AW'(1);
            end
            if (pop) begin
                rptr <= rptr + AW'(1);
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : vmf_fifo

//--- src/vmf_framer.sv
// Vehicle message sequencer, frame builder and serial transmitter
//
// Behaviour
// - Serial line runs 57.6 kbit/s, 8 data bits, no parity, one stop bit.
// - No flow control; frames are sent as events occur.
// - Frame is two sync bytes, message block, then one checksum byte.
// - First sync byte is 0xA5.
// - Second sync byte is 0x5A, before any message byte.
// - Checksum is XOR of all message block bytes, sync excluded.
// - Multi-byte fields go least significant byte first.
// - First-beam detect allocates a new vehicle number and sends message 1.
// - Second-beam detect sends number, speed and first-beam edges.
// - First-beam end sends number and second-beam edges.
// - Second-beam end pulses camera trigger and sends number only.
// - Camera trigger is one active-low pulse of one microsecond.
// - Classification follows second-beam end with class, length, width, speed.
// - Normal vehicle gives five messages with one vehicle number, in order.
// - Reverse crossing sends events as they occur; only a first-beam detect allocates a number.
// - Self-test failures queue a self-test report message.
// - First message block byte is the message identifier.
// - Vehicle number is one byte, allocated fresh by each first-beam detect accepted while event_ready is high.
`timescale 1ns/1ps
module vmf_framer
    import vmf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic beam1_detect,
    input wire logic beam2_detect,
    input wire logic beam1_end,
    input wire logic beam2_end,
    input wire logic class_ready,
    input wire logic self_test_fail,
    input wire logic [15:0] self_test_bits,
    input wire vmf_edges_s beam1_edges,
    input wire vmf_edges_s beam2_edges,
    input wire logic [7:0] speed,
    input wire vmf_class_s class_data,
    output logic event_ready,
    output logic busy,
    output logic [7:0] vehicle_number,
    output logic camera_trigger_n,
    output logic serial_tx
);
    typedef enum logic [1:0] {FR_IDLE, FR_SYNC1, FR_SYNC2, FR_BODY} vmf_frame_e;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} vmf_tx_e;

    vmf_frame_e fstate;
    vmf_tx_e tstate;
    logic [7:0] body [8];
    logic [3:0] body_len;
    logic [3:0] body_idx;
    logic [7:0] csum;
    logic [7:0] next_vehicle;
    logic [3:0] next_len;
    logic [7:0] next_body [8];
    logic take;
    logic any_event;
    logic [8:0] push_data;
    logic push_valid;
    logic push_ready;
    logic [8:0] pop_data;
    logic pop_valid;
    logic pop_ready;
    logic [7:0] trig_cnt;
    logic [15:0] bit_cnt;
    logic [2:0] bit_idx;
    logic [7:0] shifter;

    // Event priority: lower value wins when several arrive together
    assign any_event = beam1_detect | beam2_detect | beam1_end | beam2_end
        | class_ready | self_test_fail;
    assign event_ready = (fstate == FR_IDLE);
    assign busy = (fstate != FR_IDLE) || pop_valid || (tstate != TX_IDLE);
    assign take = any_event && event_ready;

    // Allocate a new number only on a first-beam detect
    always_comb begin
        next_vehicle = vehicle_number;
        if (beam1_detect) begin
            next_vehicle = vehicle_number + 8'h01;
        end else if (beam2_detect && !beam1_detect) begin
            next_vehicle = vehicle_number;
        end
    end

    // Message block assembly, identifier first, wide fields low byte first
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            next_body[i] = 8'h00;
        end
        next_len = 4'h0;
        if (beam1_detect) begin
            next_body[0] = MSG_B1_DET;
            next_body[1] = next_vehicle;
            next_body[2] = beam1_edges.left;
            next_body[3] = beam1_edges.right;
            next_len = 4'h4;
        end else if (beam2_detect) begin
            next_body[0] = MSG_B2_DET;
            next_body[1] = vehicle_number;
            next_body[2] = beam1_edges.left;
            next_body[3] = beam1_edges.right;
            next_body[4] = speed;
            next_len = 4'h5;
        end else if (beam1_end) begin
            next_body[0] = MSG_B1_END;
            next_body[1] = vehicle_number;
            next_body[2] = beam2_edges.left;
            next_body[3] = beam2_edges.right;
            next_len = 4'h4;
        end else if (beam2_end) begin
            next_body[0] = MSG_B2_END;
            next_body[1] = vehicle_number;
            next_len = 4'h2;
        end else if (class_ready) begin
            next_body[0] = MSG_CLASSIFY;
            next_body[1] = vehicle_number;
            next_body[2] = class_data.vclass;
            next_body[3] = class_data.length[7:0];
            next_body[4] = class_data.length[15:8];
            next_body[5] = class_data.width;
            next_body[6] = class_data.speed;
            next_len = 4'h7;
        end else if (self_test_fail) begin
            next_body[0] = MSG_SELF_TEST;
            next_body[1] = self_test_bits[7:0];
            next_body[2] = self_test_bits[15:8];
            next_len = 4'h3;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            vehicle_number <= VEH_NUM_RESET;
        end else if (take) begin
            vehicle_number <= next_vehicle;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (take) begin
            for (int i = 0; i < 8; i++) begin
                body[i] <= next_body[i];
            end
        end
    end

    // Frame builder: sync pair, body, checksum into the FIFO
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fstate <= FR_IDLE;
            body_len <= 4'h0;
            body_idx <= 4'h0;
            csum <= 8'h00;
        end else begin
            case (fstate)
                FR_IDLE: begin
                    if (take) begin
                        body_len <= next_len;
                        body_idx <= 4'h0;
                        csum <= 8'h00;
                        fstate <= FR_SYNC1;
                    end
                end
                FR_SYNC1: begin
                    if (push_ready) begin
                        fstate <= FR_SYNC2;
                    end
                end
                FR_SYNC2: begin
                    if (push_ready) begin
                        fstate <= FR_BODY;
                    end
                end
                FR_BODY: begin
                    if (push_ready) begin
                        if (body_idx == body_len) begin
                            fstate <= FR_IDLE;
                        end else begin
                            csum <= csum ^ body[body_idx[2:0]];
                            body_idx <= body_idx + 4'h1;
                        end
                    end
                end
                default: fstate <= FR_IDLE;
            endcase
        end
    end

    always_comb begin
        push_valid = 1'b0;
        push_data = 9'h000;
        case (fstate)
            FR_SYNC1: begin
                push_valid = 1'b1;
                push_data = {1'b0, SYNC_FIRST};
            end
            FR_SYNC2: begin
                push_valid = 1'b1;
                push_data = {1'b0, SYNC_SECOND};
            end
            FR_BODY: begin
                push_valid = 1'b1;
                if (body_idx == body_len) begin
                    push_data = {1'b1, csum};
                end else begin
                    push_data = {1'b0, body[body_idx[2:0]]};
                end
            end
            default: begin
                push_valid = 1'b0;
                push_data = 9'h000;
            end
        endcase
    end

    vmf_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .in_data(push_data),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .out_data(pop_data),
        .out_valid(pop_valid),
        .out_ready(pop_ready)
    );

    // Camera trigger: active-low pulse on second-beam end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            trig_cnt <= 8'h00;
            camera_trigger_n <= 1'b1;
        end else if (take && beam2_end && !beam1_detect && !beam2_detect && !beam1_end) begin
            trig_cnt <= 8'(TRIG_CYCLES - 1);
            camera_trigger_n <= 1'b0;
        end else if (trig_cnt != 8'h00) begin
            trig_cnt <= trig_cnt - 8'h01;
        end else begin
            camera_trigger_n <= 1'b1;
        end
    end

    // 8N1 transmitter, LSB first
    assign pop_ready = (tstate == TX_IDLE);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tstate <= TX_IDLE;
            bit_cnt <= 16'h0000;
            bit_idx <= 3'h0;
            shifter <= 8'h00;
            serial_tx <= 1'b1;
        end else begin
            case (tstate)
                TX_IDLE: begin
                    serial_tx <= 1'b1;
                    if (pop_valid) begin
                        shifter <= pop_data[7:0];
                        bit_cnt <= 16'(BIT_CYCLES - 1);
                        serial_tx <= 1'b0;
                        tstate <= TX_START;
                    end
                end
                TX_START: begin
                    if (bit_cnt == 16'h0000) begin
                        bit_cnt <= 16'(BIT_CYCLES - 1);
                        serial_tx <= shifter[0];
                        bit_idx <= 3'h0;
                        tstate <= TX_DATA;
                    end else begin
                        bit_cnt <= bit_cnt - 16'h0001;
                    end
                end
                TX_DATA: begin
                    if (bit_cnt == 16'h0000) begin
                        bit_cnt <= 16'(BIT_CYCLES - 1);
                        if (bit_idx == 3'h7) begin
                            serial_tx <= 1'b1;
                            tstate <= TX_STOP;
                        end else begin
                            serial_tx <= shifter[bit_idx + 3'h1];
                            bit_idx <= bit_idx + 3'h1;
                        end
                    end else begin
                        bit_cnt <= bit_cnt - 16'h0001;
                    end
                end
                TX_STOP: begin
                    if (bit_cnt == 16'h0000) begin
                        tstate <= TX_IDLE;
                    end else begin
                        bit_cnt <= bit_cnt - 16'h0001;
                    end
                end
                default: tstate <= TX_IDLE;
            endcase
        end
    end
endmodule : vmf_framer

//--- bench/vmf_framer_monitor.sv
// Checker of the framer's port behaviour
`timescale 1ns/1ps
module vmf_framer_monitor
    import vmf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic beam1_detect,
    input wire logic beam2_detect,
    input wire logic beam1_end,
    input wire logic beam2_end,
    input wire logic class_ready,
    input wire logic self_test_fail,
    input wire logic event_ready,
    input wire logic busy,
    input wire logic [7:0] vehicle_number,
    input wire logic camera_trigger_n,
    input wire logic serial_tx
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    logic any_ev;
    logic take;
    logic trig_take;
    assign any_ev = beam1_detect | beam2_detect | beam1_end | beam2_end | class_ready
        | self_test_fail;
    assign take = any_ev & event_ready;
    assign trig_take = take & beam2_end & ~beam1_detect & ~beam2_detect & ~beam1_end;
    a_trig_width: assert property ($fell(camera_trigger_n) |-> (!camera_trigger_n)[*8]
        ##1 !camera_trigger_n ##1 !camera_trigger_n ##1 camera_trigger_n)
        else $error("trigger pulse width wrong");
    a_trig_cause: assert property ($fell(camera_trigger_n) |-> $past(trig_take)
        || $past(trig_take, 2)) else $error("trigger without end event");
    a_trig_fires: assert property (trig_take |-> ##[1:2] !camera_trigger_n)
        else $error("trigger missing");
    a_num_alloc: assert property (beam1_detect && event_ready |=>
        vehicle_number == $past(vehicle_number) + 8'h01) else $error("number not allocated");
    a_num_hold: assert property (!(beam1_detect && event_ready) |=>
        $stable(vehicle_number)) else $error("number changed");
    a_ready_drop: assert property (take |=> !event_ready) else $error("ready stayed");
    a_busy_frame: assert property (!event_ready |-> busy) else $error("not busy");
    a_tx_idle: assert property (!busy |-> serial_tx) else $error("line not idle");
    a_tx_start: assert property (take && !busy |-> ##[1:5] !serial_tx)
        else $error("no start bit");
    c_trig: cover property (trig_take);
    c_alloc: cover property (beam1_detect && event_ready);
    c_start: cover property ($fell(serial_tx));
    c_refused: cover property (any_ev && !event_ready);
endmodule : vmf_framer_monitor

//--- bench/vmf_host_model.sv
// Roadside receiver model decoding the serial line
`timescale 1ns/1ps
module vmf_host_model
    import vmf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic serial_tx,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_bad
);
    // Listen only, never signals back
    int cnt;
    int bitn;
    logic act;
    logic [7:0] sh;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            act <= 1'b0;
            cnt <= 0;
            bitn <= 0;
            sh <= 8'h00;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            rx_bad <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (!act) begin
                act <= !serial_tx;
                cnt <= 1;
                bitn <= 0;
            end else begin
                cnt <= (cnt == BIT_CYCLES - 1) ? 0 : cnt + 1;
                if (cnt == BIT_CYCLES - 1) begin
                    bitn <= bitn + 1;
                end
                if (cnt == BIT_CYCLES / 2) begin
                    if (bitn == 0 && serial_tx) begin
                        act <= 1'b0;
                        rx_bad <= 1'b1;
                    end else if (bitn >= 1 && bitn <= 8) begin
                        sh <= {serial_tx, sh[7:1]};
                    end else if (bitn == 9) begin
                        act <= 1'b0;
                        rx_data <= sh;
                        rx_valid <= 1'b1;
                        rx_bad <= !serial_tx;
                    end
                end
            end
        end
    end
endmodule : vmf_host_model

//--- bench/tb.sv
// Self-checking bench of the vehicle message framer
`timescale 1ns/1ps
module tb;
    import vmf_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [5:0] ev = 6'h00;
    logic [15:0] self_test_bits = 16'h0000;
    vmf_edges_s beam1_edges = '0;
    vmf_edges_s beam2_edges = '0;
    logic [7:0] speed = 8'h00;
    vmf_class_s class_data = '0;
    logic event_ready, busy, camera_trigger_n, serial_tx, rx_valid, rx_bad;
    logic [7:0] vehicle_number, rx_data;
    logic [7:0] exp_q[$];
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    vmf_framer u_vmf_framer (.clk_sys(clk_sys), .nrst(nrst), .beam1_detect(ev[0]),
        .beam2_detect(ev[1]), .beam1_end(ev[2]), .beam2_end(ev[3]), .class_ready(ev[4]),
        .self_test_fail(ev[5]), .self_test_bits(self_test_bits), .beam1_edges(beam1_edges),
        .beam2_edges(beam2_edges), .speed(speed), .class_data(class_data),
        .event_ready(event_ready), .busy(busy), .vehicle_number(vehicle_number),
        .camera_trigger_n(camera_trigger_n), .serial_tx(serial_tx));
    vmf_host_model u_vmf_host_model (.clk_sys(clk_sys), .nrst(nrst), .serial_tx(serial_tx),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_bad(rx_bad));
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (!ok) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic expect_frame(input logic [7:0] body[$]);
        logic [7:0] sum;
        sum = 8'h00;
        exp_q.push_back(SYNC_FIRST);
        exp_q.push_back(SYNC_SECOND);
        foreach (body[i]) begin
            exp_q.push_back(body[i]);
            sum = sum ^ body[i];
        end
        exp_q.push_back(sum);
    endtask : expect_frame
    task automatic fire(input logic [5:0] mask);
        int k;
        k = 0;
        while (event_ready !== 1'b1 && k < 20000) begin
            @(negedge clk_sys);
            k++;
        end
        check(event_ready === 1'b1, "ready wait");
        beam1_edges = vmf_edges_s'(16'($urandom));
        beam2_edges = vmf_edges_s'(16'($urandom));
        speed = 8'($urandom);
        class_data = vmf_class_s'({$urandom, 8'($urandom)});
        self_test_bits = 16'($urandom);
        ev = mask;
        @(negedge clk_sys);
        ev = 6'h00;
    endtask : fire
    task automatic trig_quiet();
        repeat (12) begin
            @(negedge clk_sys);
            check(camera_trigger_n === 1'b1, "stray trigger");
        end
    endtask : trig_quiet
    always @(negedge clk_sys) begin
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(1'b0, "extra byte");
            end else begin
                check(rx_data === exp_q.pop_front() && rx_bad === 1'b0, "byte mismatch");
            end
        end
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 100000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(32'hda9b9fbe));
        repeat (20) @(negedge clk_sys);
        check(vehicle_number === VEH_NUM_RESET && busy === 1'b0, "reset");
        check(serial_tx === 1'b1 && camera_trigger_n === 1'b1, "reset pins");
        nrst = 1'b1;
        @(negedge clk_sys);
        fire(6'h01);
        check(vehicle_number === 8'h00, "first number");
        expect_frame('{MSG_B1_DET, 8'h00, beam1_edges.left, beam1_edges.right});
        fire(6'h02);
        expect_frame('{MSG_B2_DET, 8'h00, beam1_edges.left, beam1_edges.right, speed});
        fire(6'h04);
        expect_frame('{MSG_B1_END, 8'h00, beam2_edges.left, beam2_edges.right});
        fire(6'h08);
        expect_frame('{MSG_B2_END, 8'h00});
        n = 0;
        while (camera_trigger_n !== 1'b0 && n < 3) begin
            @(negedge clk_sys);
            n++;
        end
        check(camera_trigger_n === 1'b0, "no trigger");
        n = 0;
        while (camera_trigger_n === 1'b0 && n < 30) begin
            @(negedge clk_sys);
            n++;
        end
        check(n === TRIG_CYCLES, "trigger width");
        fire(6'h10);
        expect_frame('{MSG_CLASSIFY, 8'h00, class_data.vclass, class_data.length[7:0],
            class_data.length[15:8], class_data.width, class_data.speed});
        check(vehicle_number === 8'h00, "number kept");
        fire(6'h0a);
        expect_frame('{MSG_B2_DET, 8'h00, beam1_edges.left, beam1_edges.right, speed});
        trig_quiet();
        fire(6'h20);
        expect_frame('{MSG_SELF_TEST, self_test_bits[7:0], self_test_bits[15:8]});
        ev = 6'h01;
        @(negedge clk_sys);
        ev = 6'h00;
        check(vehicle_number === 8'h00, "refused event taken");
        while (exp_q.size() != 0 || busy !== 1'b0) begin
            @(negedge clk_sys);
        end
        repeat (200) @(negedge clk_sys);
        check(exp_q.size() == 0, "bytes missing");
        end_sim();
    end
endmodule : tb
bind vmf_framer vmf_framer_monitor u_vmf_framer_monitor (.clk_sys(clk_sys), .nrst(nrst),
    .beam1_detect(beam1_detect), .beam2_detect(beam2_detect), .beam1_end(beam1_end),
    .beam2_end(beam2_end), .class_ready(class_ready), .self_test_fail(self_test_fail),
    .event_ready(event_ready), .busy(busy), .vehicle_number(vehicle_number),
    .camera_trigger_n(camera_trigger_n), .serial_tx(serial_tx));
